// file: cca_channel.sv
// One capture/compare module: edge capture, match, toggle, pulse-width and frequency output
`timescale 1ns/1ps
module cca_channel (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Configuration and shared counter
  input wire cca_pkg::cca_mode_s mode_in,
  input wire logic [15:0] cmp_in,
  input wire logic [15:0] cnt_in,
  // Synchronised pin level
  input wire logic pin_sync_in,
  // Events and pin drive
  output cca_pkg::cca_ch_out_s ev_out
);

  cca_pkg::cca_ch_state_s st_q;
  cca_pkg::cca_ch_state_s st_d;
  logic eq_full;
  logic eq_lo;
  logic hit_full;
  logic hit_lo;
  logic rise;
  logic fall;
  logic pwm_lvl;
  logic freq_mode;

  // Compare against the shared counter; events fire when equality begins
  assign eq_full = (cnt_in == cmp_in);
  assign eq_lo = (cnt_in[7:0] == cmp_in[7:0]);
  assign hit_full = mode_in.comp_en && eq_full && !st_q.eq_prev;
  assign hit_lo = mode_in.comp_en && eq_lo && !st_q.eq_lo_prev;
  assign rise = pin_sync_in && !st_q.pin_prev;
  assign fall = !pin_sync_in && st_q.pin_prev;
  assign freq_mode = mode_in.toggle_en && mode_in.pwm_en;

  // Pulse width: pin high from the compare value to the wrap of the chosen width
  always_comb begin
    if (mode_in.width16) begin
      pwm_lvl = (cnt_in >= cmp_in);
    end else begin
      pwm_lvl = (cnt_in[7:0] >= cmp_in[7:0]);
    end
  end

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.pin_prev = pin_sync_in;
    st_d.eq_prev = eq_full;
    st_d.eq_lo_prev = eq_lo;
    if (freq_mode && hit_lo) begin
      st_d.pin_lvl = !st_q.pin_lvl;
    end else if (mode_in.toggle_en && !mode_in.pwm_en && hit_full) begin
      st_d.pin_lvl = !st_q.pin_lvl;
    end
  end

  // Event and pin outputs; pin drive only in output modes
  always_comb begin
    ev_out.capture = (mode_in.cap_rise && rise) || (mode_in.cap_fall && fall);
    ev_out.flag_set = ev_out.capture || (mode_in.match_en && hit_full);
    ev_out.freq_step = freq_mode && hit_lo;
    ev_out.pin_oe = mode_in.comp_en && (mode_in.toggle_en || mode_in.pwm_en);
    if (mode_in.pwm_en && !mode_in.toggle_en) begin
      ev_out.pin_out = mode_in.comp_en && pwm_lvl;
    end else begin
      ev_out.pin_out = st_q.pin_lvl;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// file: cca_pin_model.sv
// Behavioural model of the outside circuits on the module pins
`timescale 1ns/1ps
module cca_pin_model #(
  parameter int unsigned NUM_CH = 3
) (
  // Level applied from outside
  input wire logic [NUM_CH-1:0] ext_lvl_in,
  // Module drive
  input wire logic [NUM_CH-1:0] drv_in,
  input wire logic [NUM_CH-1:0] drv_oe_in,
  // Resolved wire level
  output logic [NUM_CH-1:0] wire_out
);
  // Outside circuit backs off where the module drives, so no contention
  assign wire_out = (drv_oe_in & drv_in) | (~drv_oe_in & ext_lvl_in);
endmodule

// file: cca_pkg.sv
// Package with register map, field layout and carrier types of the counter array
package cca_pkg;

  // Number of capture/compare modules and widths
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CNT_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE0 = 8'hda;
  localparam logic [7:0] IDX_MODE1 = 8'hdb;
  localparam logic [7:0] IDX_MODE2 = 8'hdc;
  localparam logic [7:0] IDX_CMP1_LO = 8'he9;
  localparam logic [7:0] IDX_CMP2_LO = 8'heb;
  localparam logic [7:0] IDX_CNT_LO = 8'hf9;
  localparam logic [7:0] IDX_CNT_HI = 8'hfa;
  localparam logic [7:0] IDX_CMP0_LO = 8'hfb;
  localparam logic [7:0] IDX_CMP0_HI = 8'he0;
  localparam logic [7:0] IDX_CMP1_HI = 8'he1;
  localparam logic [7:0] IDX_CMP2_HI = 8'he2;
  localparam logic [7:0] IDX_CTRL = 8'hd0;
  localparam logic [7:0] IDX_STATUS = 8'hd1;
  localparam logic [7:0] IDX_MASK = 8'hd2;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // Mode register bit positions
  localparam int unsigned MB_WIDTH16 = 7;
  localparam int unsigned MB_COMP = 6;
  localparam int unsigned MB_CAP_RISE = 5;
  localparam int unsigned MB_CAP_FALL = 4;
  localparam int unsigned MB_MATCH = 3;
  localparam int unsigned MB_TOGGLE = 2;
  localparam int unsigned MB_PWM = 1;
  localparam int unsigned MB_FLAG_IE = 0;

  // Control, status and mask bit positions
  localparam int unsigned CB_RUN = 6;
  localparam int unsigned SB_OVF = 7;

  // Per-module mode fields, in register bit order
  typedef struct packed {
    logic width16;
    logic comp_en;
    logic cap_rise;
    logic cap_fall;
    logic match_en;
    logic toggle_en;
    logic pwm_en;
    logic flag_ie;
  } cca_mode_s;

  // Per-module events and pin drive
  typedef struct packed {
    logic capture;
    logic flag_set;
    logic freq_step;
    logic pin_out;
    logic pin_oe;
  } cca_ch_out_s;

  // State of one module
  typedef struct packed {
    logic pin_prev;
    logic eq_prev;
    logic eq_lo_prev;
    logic pin_lvl;
  } cca_ch_state_s;

  // State of the top level
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] mode;
    logic [NUM_CH-1:0][CNT_W-1:0] cmp;
    logic [CNT_W-1:0] cnt;
    logic run;
    logic [7:0] status;
    logic [7:0] mask;
    logic [NUM_CH-1:0] pin_s1;
    logic [NUM_CH-1:0] pin_s2;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } cca_top_s;

endpackage

// file: cca_props.sv
// Port-level checks of bus answers, pin enables and interrupt masking
`timescale 1ns/1ps
module cca_props #(
  parameter int unsigned NUM_CH = 3
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Register bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Pins and interrupt
  input wire logic [NUM_CH-1:0] pin_oe_out,
  input wire logic irq_out
);
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [NUM_CH-1:0][7:0] mode_q;
  logic [7:0] mask_q;
  logic [NUM_CH-1:0] oe_exp;
  logic irq_off;
  logic take;
  logic mapped;
  // Address phase decode
  assign take = hsel_in && htrans_in[1] && hready_in;
  assign mapped = haddr_in[31:10] == 22'h0;
  // Shadow of mode and mask bytes, updated at the same edge as the design
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      mode_q <= '0;
      mask_q <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite_in && mapped;
      wr_idx_q <= haddr_in[9:2];
      if (wr_pend_q && wr_idx_q == cca_pkg::IDX_MASK) begin
        mask_q <= hwdata_in[7:0];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_pend_q && wr_idx_q == cca_pkg::IDX_MODE0 + 8'(i)) begin
          mode_q[i] <= hwdata_in[7:0];
        end
      end
    end
  end
  // Drive only with comparator on and an output mode; silent irq when nothing can fire
  always_comb begin
    irq_off = !mask_q[7];
    for (int i = 0; i < NUM_CH; i++) begin
      oe_exp[i] = mode_q[i][6] && (mode_q[i][2] || mode_q[i][1]);
      irq_off = irq_off && !(mask_q[i] && mode_q[i][0]);
    end
  end
  AST_OKAY: assert property (hresp_out == 1'b0) else $error("Response not OKAY");
  AST_READY: assert property (hreadyout_out == 1'b1) else $error("Wait state inserted");
  AST_UPPER: assert property (hrdata_out[31:8] == 24'h0) else $error("Upper read bits set");
  AST_HOLD: assert property (!(take && !hwrite_in) |=> $stable(hrdata_out))
    else $error("Read data moved without a read");
  AST_UNMAP: assert property (take && !hwrite_in && !mapped |=> hrdata_out == 32'h0)
    else $error("Unmapped read not zero");
  AST_MODE_RD: assert property (
    take && !hwrite_in && mapped && haddr_in[9:2] == cca_pkg::IDX_MODE0
    |=> hrdata_out[7:0] == $past(mode_q[0])) else $error("Mode readback wrong");
  AST_OE: assert property (pin_oe_out == oe_exp) else $error("Pin enable wrong");
  AST_IRQ_MASK: assert property (irq_off |-> !irq_out) else $error("Masked irq seen");
endmodule
bind cca_top cca_props #(.NUM_CH(NUM_CH)) u_cca_props (.clk_sys_in, .nrst_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .pin_oe_out, .irq_out);

// file: cca_top.sv
// Counter array top: shared counter, three capture/compare modules, AHB-Lite registers
//
// Overview of operation
// - width-select bit picks 16-bit or 8-bit pulse width
// - comparator works only while its enable is set
// - rising pin edge captures when rising enable set
// - falling pin edge captures when falling enable set
// - counter equal to compare register sets flag
// - toggle enable inverts pin on each match
// - toggle plus pulse width gives frequency output
// - pulse width enable drives modulated waveform on pin
// - flag raises interrupt only with flag interrupt enable
// - three modules, each with own mode register
// - counter readable and writable as two bytes
// - each module has 16-bit compare register, two bytes
// - overflow flag set on wrap, held until cleared
// - flags set by hardware, cleared only by software
// - counter advances only while run control set
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module cca_top #(
  parameter int unsigned NUM_CH = cca_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Module pins, two-way
  input wire logic [NUM_CH-1:0] pin_in,
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe_out,
  // Interrupt
  output logic irq_out
);

  cca_pkg::cca_top_s st_q;
  cca_pkg::cca_top_s st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  cca_pkg::cca_ch_out_s [NUM_CH-1:0] ch_ev;
  logic addr_phase;
  logic [7:0] a_idx;
  logic [7:0] wbyte;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] flag_ie_bits;
  logic [7:0] rd_byte;

  // Reset release through two flip-flops, asserted asynchronously
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Modules share the counter; each drives one pin
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    cca_channel u_ch (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n),
      .mode_in(cca_pkg::cca_mode_s'(st_q.mode[i])),
      .cmp_in(st_q.cmp[i]),
      .cnt_in(st_q.cnt),
      .pin_sync_in(st_q.pin_s2[i]),
      .ev_out(ch_ev[i])
    );
    assign pin_out[i] = ch_ev[i].pin_out;
    assign pin_oe_out[i] = ch_ev[i].pin_oe;
  end

  // Address phase decode; word index sits above the byte offset
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;
  assign a_idx = haddr_in[9:2];
  assign wbyte = hwdata_in[7:0];

  // Read data for an index; unmapped and high addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (haddr_in[31:10] == 22'h000000) begin
      unique case (a_idx)
        cca_pkg::IDX_MODE0: rd_byte = st_q.mode[0];
        cca_pkg::IDX_MODE1: rd_byte = st_q.mode[1];
        cca_pkg::IDX_MODE2: rd_byte = st_q.mode[2];
        cca_pkg::IDX_CNT_LO: rd_byte = st_q.cnt[7:0];
        cca_pkg::IDX_CNT_HI: rd_byte = st_q.cnt[15:8];
        cca_pkg::IDX_CMP0_LO: rd_byte = st_q.cmp[0][7:0];
        cca_pkg::IDX_CMP1_LO: rd_byte = st_q.cmp[1][7:0];
        cca_pkg::IDX_CMP2_LO: rd_byte = st_q.cmp[2][7:0];
        cca_pkg::IDX_CMP0_HI: rd_byte = st_q.cmp[0][15:8];
        cca_pkg::IDX_CMP1_HI: rd_byte = st_q.cmp[1][15:8];
        cca_pkg::IDX_CMP2_HI: rd_byte = st_q.cmp[2][15:8];
        cca_pkg::IDX_CTRL: rd_byte = {1'b0, st_q.run, 6'h00};
        cca_pkg::IDX_STATUS: rd_byte = st_q.status;
        cca_pkg::IDX_MASK: rd_byte = st_q.mask;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Hardware events gathered in status layout
  always_comb begin
    set_bits = 8'h00;
    flag_ie_bits = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      set_bits[i] = ch_ev[i].flag_set;
      flag_ie_bits[i] = st_q.mode[i][cca_pkg::MB_FLAG_IE];
    end
    set_bits[cca_pkg::SB_OVF] = st_q.run && (st_q.cnt == 16'hffff);
    flag_ie_bits[cca_pkg::SB_OVF] = 1'b1;
  end

  // Software clears status bits by writing ones
  always_comb begin
    clr_bits = 8'h00;
    if (st_q.wr_pend && st_q.wr_idx == cca_pkg::IDX_STATUS) begin
      clr_bits = wbyte;
    end
  end

  // Next state: registers, counter, captures, synchronisers
  always_comb begin
    st_d = st_q;
    st_d.pin_s1 = pin_in;
    st_d.pin_s2 = st_q.pin_s1;

    // Counter runs on every system clock while enabled
    if (st_q.run) begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end

    // Capture loads the counter; frequency mode steps the low byte by the high byte
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_ev[i].capture) begin
        st_d.cmp[i] = st_q.cnt;
      end else if (ch_ev[i].freq_step) begin
        st_d.cmp[i][7:0] = st_q.cmp[i][7:0] + st_q.cmp[i][15:8];
      end
    end

    // Set wins over a clear in the same cycle
    st_d.status = (st_q.status & ~clr_bits) | set_bits;

    // Data phase of a write; a bus write beats a same-cycle hardware update
    if (st_q.wr_pend) begin
      unique case (st_q.wr_idx)
        cca_pkg::IDX_MODE0: st_d.mode[0] = wbyte;
        cca_pkg::IDX_MODE1: st_d.mode[1] = wbyte;
        cca_pkg::IDX_MODE2: st_d.mode[2] = wbyte;
        cca_pkg::IDX_CNT_LO: st_d.cnt[7:0] = wbyte;
        cca_pkg::IDX_CNT_HI: st_d.cnt[15:8] = wbyte;
        cca_pkg::IDX_CMP0_LO: st_d.cmp[0][7:0] = wbyte;
        cca_pkg::IDX_CMP1_LO: st_d.cmp[1][7:0] = wbyte;
        cca_pkg::IDX_CMP2_LO: st_d.cmp[2][7:0] = wbyte;
        cca_pkg::IDX_CMP0_HI: st_d.cmp[0][15:8] = wbyte;
        cca_pkg::IDX_CMP1_HI: st_d.cmp[1][15:8] = wbyte;
        cca_pkg::IDX_CMP2_HI: st_d.cmp[2][15:8] = wbyte;
        cca_pkg::IDX_CTRL: st_d.run = wbyte[cca_pkg::CB_RUN];
        cca_pkg::IDX_MASK: st_d.mask = wbyte;
        default: st_d.mask = st_d.mask;
      endcase
    end

    // Address phase: latch writes, fetch read data so it stands in the data phase
    st_d.wr_pend = 1'b0;
    if (addr_phase) begin
      st_d.wr_pend = hwrite_in && (haddr_in[31:10] == 22'h000000);
      st_d.wr_idx = a_idx;
      if (!hwrite_in) begin
        st_d.rdata = {24'h000000, rd_byte};
      end
    end
  end

  // State register; all control state clears at reset
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q.mode <= {NUM_CH{cca_pkg::MODE_RST}};
      st_q.cmp <= {NUM_CH{cca_pkg::CMP_RST}};
      st_q.cnt <= cca_pkg::CNT_RST;
      st_q.run <= 1'b0;
      st_q.status <= cca_pkg::STATUS_RST;
      st_q.mask <= cca_pkg::MASK_RST;
      st_q.pin_s1 <= '0;
      st_q.pin_s2 <= '0;
      st_q.wr_pend <= 1'b0;
      st_q.wr_idx <= 8'h00;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = st_q.rdata;

  // Module flags need both the mask and their own interrupt enable
  assign irq_out = |(st_q.status & st_q.mask & flag_ie_bits);

endmodule

// file: testbench.sv
// Self-checking bench of the counter array over its register bus and pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end \
end
module testbench;
  localparam logic [7:0] ST = cca_pkg::IDX_STATUS;
  localparam logic [7:0] CT = cca_pkg::IDX_CTRL;
  localparam logic [7:0] CL = cca_pkg::IDX_CNT_LO;
  localparam logic [7:0] CH = cca_pkg::IDX_CNT_HI;
  logic clk_sys_in;
  logic nrst_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic hready_in;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic [2:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] pin_oe_out;
  logic irq_out;
  logic [2:0] ext_lvl = 3'h0;
  logic p;
  logic [21:0] hi_addr = 22'h0;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] regs [11] = '{cca_pkg::IDX_MODE0, cca_pkg::IDX_MODE1, cca_pkg::IDX_MODE2,
    cca_pkg::IDX_CMP0_LO, cca_pkg::IDX_CMP0_HI, cca_pkg::IDX_CMP1_LO, cca_pkg::IDX_CMP1_HI,
    cca_pkg::IDX_CMP2_LO, cca_pkg::IDX_CMP2_HI, CL, CH};
  // Single slave, so its ready is the bus ready
  assign hready_in = hreadyout_out;
  cca_top u_cca_top (.clk_sys_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .pin_in, .pin_out, .pin_oe_out, .irq_out);
  cca_pin_model u_cca_pin_model (.ext_lvl_in(ext_lvl), .drv_in(pin_out),
    .drv_oe_in(pin_oe_out), .wire_out(pin_in));
  // 100 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bounded wait for ready; a stuck bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (hready_in !== 1'b1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] wd,
      output logic [7:0] rdv);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {hi_addr, idx, 2'h0};
    hwrite_in <= w;
    wait_rdy();
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, wd};
    wait_rdy();
    rdv = hrdata_out[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] t;
    xfer(idx, 1'b1, d, t);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    xfer(idx, 1'b0, 8'h00, v);
    `CHK("reg", e, v)
  endtask
  // Let edge updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic pin_chk(input logic e);
    cyc(2);
    `CHK("pin2", e, pin_out[2])
  endtask
  task automatic irq_chk(input logic e);
    cyc(1);
    `CHK("irq", e, irq_out)
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    // Counter stopped, so its bytes read back as written
    foreach (regs[i]) wr(regs[i], 8'h31 + 8'(i));
    foreach (regs[i]) rd(regs[i], 8'h31 + 8'(i));
    // High address bits set: the write is dropped and the read gives zero
    hi_addr = 22'h1;
    wr(cca_pkg::IDX_MODE0, 8'h5a);
    rd(cca_pkg::IDX_MODE0, 8'h00);
    hi_addr = 22'h0;
    rd(cca_pkg::IDX_MODE0, 8'h31);
    wr(cca_pkg::IDX_MODE1, 8'h21);
    wr(CL, 8'h34);
    wr(CH, 8'h12);
    ext_lvl[1] <= 1'b1;
    cyc(6);
    rd(cca_pkg::IDX_CMP1_LO, 8'h34);
    rd(cca_pkg::IDX_CMP1_HI, 8'h12);
    rd(ST, 8'h02);
    wr(cca_pkg::IDX_MASK, 8'h02);
    rd(cca_pkg::IDX_MASK, 8'h02);
    irq_chk(1'b1);
    wr(cca_pkg::IDX_MODE1, 8'h20);
    irq_chk(1'b0);
    rd(ST, 8'h02);
    wr(ST, 8'h02);
    rd(ST, 8'h00);
    wr(CL, 8'h56);
    ext_lvl[1] <= 1'b0;
    cyc(6);
    rd(cca_pkg::IDX_CMP1_LO, 8'h34);
    wr(cca_pkg::IDX_MODE1, 8'h10);
    ext_lvl[1] <= 1'b1;
    cyc(6);
    rd(cca_pkg::IDX_CMP1_LO, 8'h34);
    ext_lvl[1] <= 1'b0;
    cyc(6);
    rd(cca_pkg::IDX_CMP1_LO, 8'h56);
    wr(ST, 8'h02);
    // Match ignored while the comparator is off
    wr(cca_pkg::IDX_MODE0, 8'h08);
    wr(cca_pkg::IDX_CMP0_LO, 8'h40);
    wr(cca_pkg::IDX_CMP0_HI, 8'h00);
    wr(CL, 8'h00);
    wr(CH, 8'h00);
    wr(CT, 8'h40);
    cyc(100);
    rd(ST, 8'h00);
    wr(CT, 8'h00);
    wr(cca_pkg::IDX_MODE0, 8'h49);
    wr(cca_pkg::IDX_MASK, 8'h01);
    wr(CL, 8'h00);
    wr(CT, 8'h40);
    cyc(100);
    rd(ST, 8'h01);
    irq_chk(1'b1);
    wr(CT, 8'h00);
    wr(CL, 8'hf0);
    wr(CH, 8'hff);
    wr(CT, 8'h40);
    rd(CT, 8'h40);
    cyc(20);
    rd(ST, 8'h81);
    wr(CT, 8'h00);
    // Toggle on a single pass of the compare value
    wr(CL, 8'h00);
    wr(CH, 8'h00);
    wr(cca_pkg::IDX_CMP2_LO, 8'h20);
    wr(cca_pkg::IDX_CMP2_HI, 8'h00);
    wr(cca_pkg::IDX_MODE2, 8'h44);
    cyc(2);
    p = pin_out[2];
    wr(CT, 8'h40);
    cyc(60);
    wr(CT, 8'h00);
    pin_chk(~p);
    // 0x0090 is above the low byte 0x80 but below the word 0x0180
    wr(CL, 8'h90);
    wr(cca_pkg::IDX_CMP2_LO, 8'h80);
    wr(cca_pkg::IDX_CMP2_HI, 8'h01);
    wr(cca_pkg::IDX_MODE2, 8'h42);
    pin_chk(1'b1);
    wr(cca_pkg::IDX_MODE2, 8'hc2);
    pin_chk(1'b0);
    wr(CH, 8'h02);
    pin_chk(1'b1);
    wr(CH, 8'h00);
    wr(CL, 8'h00);
    wr(cca_pkg::IDX_CMP2_LO, 8'h10);
    wr(cca_pkg::IDX_CMP2_HI, 8'h08);
    wr(cca_pkg::IDX_MODE2, 8'h46);
    wr(CL, 8'h10);
    cyc(3);
    rd(cca_pkg::IDX_CMP2_LO, 8'h18);
    close_out();
  end
endmodule
